// *** rtl/phe_regs.sv ***
// register bank for bias hints, package enable and related feature registers
`timescale 1ns/1ps
module phe_regs
  import phe_pkg::*;
#(
  parameter int NUM_LP = 2,
  parameter int LP_BITS = 1
) (
  input wire logic core_clk, // core clock, 50 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic featBias, // bias hint feature fitted
  input wire logic featBase, // baseline hw-controlled feature fitted
  input wire logic featNotify, // interrupt control register fitted
  input wire logic featWindow, // activity window programmable
  input wire logic featPref, // preference hint programmable
  input wire logic featPkg, // package request register fitted
  input wire logic regRead, // register read strobe
  input wire logic regWrite, // register write strobe
  input wire logic [11:0] regAddr, // register address
  input wire logic [LP_BITS-1:0] regLp, // issuing logical processor
  input wire logic [63:0] regWdata, // write data
  input wire logic [63:0] capabilityIn, // live capability value
  input wire logic [63:0] changeFlagsIn, // live status value
  input wire logic [63:0] thermalIn, // live thermal status value
  input wire logic [63:0] productiveIn, // live productive count
  output logic [63:0] regRdata, // read data
  output logic regAck, // access completed, one cycle
  output logic regFault, // access refused, one cycle
  output logic [31:0] leaf6Eax, // feature query EAX
  output logic [31:0] leaf6Ecx, // feature query ECX
  output logic hwEnabled, // hw-controlled states active
  output logic legacyIgnore, // legacy control disregarded
  output logic [3:0] resolvedHint // package-resolved bias hint
);
  // per logical processor storage
  logic [3:0] biasHint [NUM_LP];
  logic [3:0] next_biasHint [NUM_LP];
  logic [63:0] coreRequest [NUM_LP];
  logic [63:0] next_coreRequest [NUM_LP];

  // package-wide storage
  logic enableBit;
  logic next_enableBit;
  logic [63:0] pkgRequest;
  logic [63:0] next_pkgRequest;
  logic [63:0] notifyCtl;
  logic [63:0] next_notifyCtl;

  // next values of the registered outputs
  logic [63:0] next_regRdata;
  logic next_regAck;
  logic next_regFault;
  logic [31:0] next_leaf6Eax;
  logic [31:0] next_leaf6Ecx;
  logic [3:0] next_resolvedHint;

  // shared write decode and access gates
  logic hitBias;
  logic hitEnable;
  logic hitCore;
  logic hitPkg;
  logic hitNotify;
  logic biasOpen;
  logic baseOpen;
  logic gatedOpen;
  logic pkgOpen;
  logic notifyOpen;
  logic [63:0] reqMask;

  // write decode; a gate mirrors the query bit so software never reaches a register it cannot see
  always_comb begin
    // write strobes only; a read changes no state
    hitBias = regWrite && (regAddr == ADDR_BIAS_HINT);
    hitEnable = regWrite && (regAddr == ADDR_MASTER_ENABLE);
    hitCore = regWrite && (regAddr == ADDR_CORE_REQUEST);
    hitPkg = regWrite && (regAddr == ADDR_PKG_REQUEST);
    hitNotify = regWrite && (regAddr == ADDR_NOTIFY_CONTROL);
    biasOpen = featBias; // see R1
    baseOpen = featBase; // see R6
    gatedOpen = featBase && enableBit; // see R16
    pkgOpen = featBase && featPkg && enableBit; // see R9 see R16
    notifyOpen = featBase && featNotify; // see R7 see R17
  end

  // an unsupported preference field reads zero and ignores writes; bits 41:32 pass even without featWindow
  always_comb begin
    reqMask = 64'h0000_07FF_00FF_FFFF;
    if (featPref) begin
      reqMask[31:24] = 8'hFF; // see R8
    end
    if (featWindow) begin
      reqMask[41:32] = 10'h3FF; // see R8
    end
  end

  // bias hint next state: only the issuing core's hint moves
  always_comb begin
    next_biasHint = biasHint;
    if (hitBias && biasOpen) begin
      next_biasHint[regLp] = regWdata[BIAS_HINT_WIDTH-1:0]; // see R2 see R4 see R20
    end
  end

  // per core request; bit 42 routes the core to the package request
  always_comb begin
    next_coreRequest = coreRequest;
    if (hitCore && gatedOpen) begin
      next_coreRequest[regLp] = regWdata & reqMask;
    end
  end

  // enable bit is set-only: a zero write or a second write changes nothing
  always_comb begin
    next_enableBit = enableBit;
    if (hitEnable && baseOpen) begin
      next_enableBit = enableBit | regWdata[ENABLE_BIT]; // see R12 see R13 see R18
    end
  end

  // package request has no routing bit; notify control keeps its two enables
  always_comb begin
    next_pkgRequest = pkgRequest;
    next_notifyCtl = notifyCtl;
    if (hitPkg && pkgOpen) begin
      next_pkgRequest = regWdata & reqMask & 64'h0000_03FF_FFFF_FFFF;
    end
    if (hitNotify && notifyOpen) begin
      next_notifyCtl = {62'h0, regWdata[1:0]};
    end
  end

  // bus response: every strobe is answered next cycle, a refused one with a fault
  always_comb begin
    next_regRdata = 64'h0;
    next_regAck = 1'b0;
    next_regFault = 1'b0;
    if (regRead || regWrite) begin
      next_regAck = 1'b1;
      unique case (regAddr)
        ADDR_BIAS_HINT: begin
          if (!biasOpen) begin
            next_regFault = 1'b1; // see R1
          end else if (regRead) begin
            next_regRdata = {60'h0, biasHint[regLp]}; // see R20
          end
        end
        ADDR_MASTER_ENABLE: begin
          if (!baseOpen) begin
            next_regFault = 1'b1; // see R6
          end else if (regRead) begin
            next_regRdata = {63'h0, enableBit}; // see R14
          end
        end
        ADDR_PERF_CAPABILITY, ADDR_CHANGE_FLAGS: begin
          if (!gatedOpen || regWrite) begin
            next_regFault = 1'b1; // see R16
          end else begin
            next_regRdata = (regAddr == ADDR_CHANGE_FLAGS) ? changeFlagsIn : {32'h0, capabilityIn[31:0]};
          end
        end
        ADDR_CORE_REQUEST: begin
          if (!gatedOpen) begin
            next_regFault = 1'b1; // see R16
          end else if (regRead) begin
            next_regRdata = coreRequest[regLp];
          end
        end
        ADDR_PKG_REQUEST: begin
          if (!pkgOpen) begin
            next_regFault = 1'b1; // see R9 see R16
          end else if (regRead) begin
            next_regRdata = pkgRequest;
          end
        end
        ADDR_NOTIFY_CONTROL: begin
          // reachable before enabling, only the feature flags matter
          if (!notifyOpen) begin
            next_regFault = 1'b1; // see R7 see R17
          end else if (regRead) begin
            next_regRdata = notifyCtl;
          end
        end
        ADDR_THERMAL_STATE: begin
          if (regWrite) begin
            next_regFault = 1'b1;
          end else begin
            next_regRdata = {48'h0, thermalIn[THERM_REASON_HI:THERM_REASON_LO], 12'h0}; // see R10
          end
        end
        ADDR_PRODUCTIVE_COUNT: begin
          if (regWrite) begin
            next_regFault = 1'b1;
          end else begin
            next_regRdata = productiveIn; // exempt from the enable gate, see R16
          end
        end
        default: begin
          next_regFault = 1'b1; // unmapped address
        end
      endcase
    end
  end

  // feature query words; the dependent bits need the baseline feature as well
  always_comb begin
    next_leaf6Eax = 32'h0;
    next_leaf6Ecx = 32'h0;
    next_leaf6Ecx[LEAF6_ECX_BIAS_BIT] = featBias; // see R1
    next_leaf6Eax[LEAF6_EAX_BASE_BIT] = featBase; // see R6
    next_leaf6Eax[LEAF6_EAX_NOTIFY_BIT] = featBase & featNotify; // see R7
    next_leaf6Eax[LEAF6_EAX_WINDOW_BIT] = featBase & featWindow; // see R8
    next_leaf6Eax[LEAF6_EAX_PREF_BIT] = featBase & featPref; // see R8
    next_leaf6Eax[LEAF6_EAX_PKG_BIT] = featBase & featPkg; // see R9
  end

  // lowest value wins since 0 means most performance
  always_comb begin
    next_resolvedHint = 4'hF;
    for (int i = 0; i < NUM_LP; i++) begin
      if (biasHint[i] < next_resolvedHint) begin
        next_resolvedHint = biasHint[i]; // see R5
      end
    end
  end

  // per core registers, one copy for each logical processor
  for (genvar g = 0; g < NUM_LP; g++) begin : gen_lp
    // each copy resets to the performance end of the scale
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        biasHint[g] <= BIAS_HINT_RESET; // see R3
        coreRequest[g] <= REQUEST_RESET;
      end else begin
        biasHint[g] <= next_biasHint[g]; // see R4
        coreRequest[g] <= next_coreRequest[g];
      end
    end
  end

  // enable bit clears on the reset pin alone; no write path leads to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableBit <= ENABLE_RESET[ENABLE_BIT]; // see R13 see R14
      hwEnabled <= ENABLE_RESET[ENABLE_BIT];
      legacyIgnore <= ENABLE_RESET[ENABLE_BIT];
    end else begin
      enableBit <= next_enableBit;
      hwEnabled <= next_enableBit; // see R18
      legacyIgnore <= next_enableBit; // see R11
    end
  end

  // package-wide request and notify control
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pkgRequest <= REQUEST_RESET;
      notifyCtl <= REQUEST_RESET;
    end else begin
      pkgRequest <= next_pkgRequest;
      notifyCtl <= next_notifyCtl;
    end
  end

  // bus response, held for one cycle only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regRdata <= 64'h0;
      regAck <= 1'b0;
      regFault <= 1'b0;
    end else begin
      regRdata <= next_regRdata;
      regAck <= next_regAck;
      regFault <= next_regFault;
    end
  end

  // query words follow the straps one cycle late
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      leaf6Eax <= 32'h0;
      leaf6Ecx <= 32'h0;
    end else begin
      leaf6Eax <= next_leaf6Eax;
      leaf6Ecx <= next_leaf6Ecx;
    end
  end

  // resolved hint trails the stored hint by one cycle, so a hint write by two
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resolvedHint <= BIAS_HINT_RESET;
    end else begin
      resolvedHint <= next_resolvedHint;
    end
  end
endmodule

// *** rtl/phe_pkg.sv ***
// constants and register map for the power-performance hint and enable register bank
//
// Operation
// R1: advertise bias hint flag; implement register 1B0H
// R2: bias hint holds values 0 to 15
// R3: bias hint resets to 0, performance first
// R4: one bias hint per logical processor
// R5: conflicting hints resolve toward performance
// R6: leaf 6 EAX bit 7 flags baseline feature
// R7: EAX bit 8 flags interrupt control register
// R8: EAX bits 9, 10 flag window, preference
// R9: EAX bit 11 flags package request register
// R10: thermal status bits 15:12 give excursion reasons
// R11: enable bit on ignores legacy performance control
// R12: enable bit settable once, later writes ignored
// R13: only hardware reset clears enable bit
// R14: enable register reads 0 at power-on
// R15: software writes zero to enable bits 63:1
// R16: feature registers accessible only once enabled
// R17: interrupt control accessible whenever feature present
// R18: enable register shared by whole package
// R19: software checks feature query before enabling
// R20: bias hint bits 63:4 read zero
package phe_pkg;
  localparam logic [11:0] ADDR_THERMAL_STATE = 12'h19C;
  localparam logic [11:0] ADDR_BIAS_HINT = 12'h1B0;
  localparam logic [11:0] ADDR_PRODUCTIVE_COUNT = 12'h64E;
  localparam logic [11:0] ADDR_MASTER_ENABLE = 12'h770;
  localparam logic [11:0] ADDR_PERF_CAPABILITY = 12'h771;
  localparam logic [11:0] ADDR_PKG_REQUEST = 12'h772;
  localparam logic [11:0] ADDR_NOTIFY_CONTROL = 12'h773;
  localparam logic [11:0] ADDR_CORE_REQUEST = 12'h774;
  localparam logic [11:0] ADDR_CHANGE_FLAGS = 12'h777;
  localparam int BIAS_HINT_WIDTH = 4;
  localparam logic [3:0] BIAS_HINT_RESET = 4'h0;
  localparam logic [63:0] ENABLE_RESET = 64'h0;
  localparam logic [63:0] REQUEST_RESET = 64'h0;
  localparam int ENABLE_BIT = 0;
  localparam int LEAF6_ECX_BIAS_BIT = 3;
  localparam int LEAF6_EAX_BASE_BIT = 7;
  localparam int LEAF6_EAX_NOTIFY_BIT = 8;
  localparam int LEAF6_EAX_WINDOW_BIT = 9;
  localparam int LEAF6_EAX_PREF_BIT = 10;
  localparam int LEAF6_EAX_PKG_BIT = 11;
  localparam int THERM_REASON_LO = 12;
  localparam int THERM_REASON_HI = 15;
endpackage

// *** sim/phe_regs_checker.sv ***
// protocol and state checks for the hint and enable register bank
`timescale 1ns/1ps
module phe_regs_checker
  import phe_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic featBias, // bias strap
  input wire logic featBase, // base strap
  input wire logic featNotify, // notify strap
  input wire logic regRead, // read strobe
  input wire logic regWrite, // write strobe
  input wire logic [11:0] regAddr, // address
  input wire logic [63:0] regWdata, // write data
  input wire logic [63:0] regRdata, // read data
  input wire logic regAck, // ack
  input wire logic regFault, // fault
  input wire logic [31:0] leaf6Eax, // query eax
  input wire logic [31:0] leaf6Ecx, // query ecx
  input wire logic hwEnabled, // enable state
  input wire logic legacyIgnore // legacy ignored
);
  // all checks sit in the one clock domain
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ack_follow_a: assert property ((regRead || regWrite) |=> regAck) else $error("no ack");
  fault_ack_a: assert property (regFault |-> regAck) else $error("fault without ack");
  gate_fault_a: assert property ((regRead || regWrite) && regAddr == ADDR_PERF_CAPABILITY && !hwEnabled
    |=> regFault) else $error("gated access let through");
  notify_open_a: assert property (regRead && regAddr == ADDR_NOTIFY_CONTROL && featNotify && featBase
    |=> !regFault) else $error("notify read refused");
  enable_set_a: assert property (regWrite && regAddr == ADDR_MASTER_ENABLE && regWdata[0] && featBase
    |=> hwEnabled) else $error("enable not set");
  enable_sticky_a: assert property (hwEnabled |=> hwEnabled) else $error("enable cleared");
  legacy_track_a: assert property (legacyIgnore == hwEnabled) else $error("legacy flag off");
  bias_upper_a: assert property (regAck && $past(regRead) && $past(regAddr) == ADDR_BIAS_HINT
    |-> regRdata[63:4] == 60'h0) else $error("bias upper bits set");
  ecx_flag_a: assert property (!$past(rst) |-> leaf6Ecx[LEAF6_ECX_BIAS_BIT] == $past(featBias))
    else $error("bias flag wrong");
  eax_flag_a: assert property (!$past(rst) |-> leaf6Eax[LEAF6_EAX_BASE_BIT] == $past(featBase))
    else $error("base flag wrong");
  // main scenarios
  cover property (regWrite && regAddr == ADDR_MASTER_ENABLE && regWdata[0]);
  cover property (regFault);
  cover property (regAck && !regFault && hwEnabled);
endmodule

bind phe_regs phe_regs_checker chk (.core_clk, .rst, .featBias, .featBase, .featNotify, .regRead, .regWrite,
  .regAddr, .regWdata, .regRdata, .regAck, .regFault, .leaf6Eax, .leaf6Ecx, .hwEnabled, .legacyIgnore);

// *** sim/phe_regs_bench.sv ***
// self-checking bench for the hint and enable register bank
`timescale 1ns/1ps
module phe_regs_bench;
  import phe_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, regRead = 1'b0, regWrite = 1'b0, feat = 1'b1;
  logic [11:0] regAddr = 12'h0;
  logic [0:0] regLp = 1'b0;
  logic [63:0] regWdata = 64'h0, regRdata;
  logic [63:0] cap = 64'hAAAA_BBBB_CCCC_DDDD, therm = 64'hFFFF_FFFF_FFFF_FFFF, prod = 64'h0123_4567_89AB_CDEF;
  logic regAck, regFault, hwEnabled, legacyIgnore;
  logic [31:0] leaf6Eax, leaf6Ecx;
  logic [3:0] resolvedHint;
  int fail_count = 0;
  int check_count = 0;
  phe_regs dut (.core_clk, .rst, .featBias(feat), .featBase(feat), .featNotify(feat), .featWindow(feat),
    .featPref(feat), .featPkg(feat), .regRead, .regWrite, .regAddr, .regLp, .regWdata, .capabilityIn(cap),
    .changeFlagsIn(cap), .thermalIn(therm), .productiveIn(prod), .regRdata, .regAck, .regFault, .leaf6Eax,
    .leaf6Ecx, .hwEnabled, .legacyIgnore, .resolvedHint);
  // 50 MHz clock
  initial forever #10 core_clk = ~core_clk;
  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // one strobe cycle, then the ack is looked at in its own cycle
  task automatic op(input logic wr, input logic [11:0] a, input logic lp, input logic [63:0] d, e,
    input logic f);
    @(negedge core_clk);
    regWrite = wr;
    regRead = !wr;
    regAddr = a;
    regLp = lp;
    regWdata = d;
    @(negedge core_clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    chk1(regAck, 1'b1);
    if (!wr && !f) chk64(regRdata, e);
    chk1(regFault, f);
  endtask
  // main sequence; waits are bounded inside op
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk64({leaf6Ecx, leaf6Eax}, 64'h0000_0008_0000_0F80);
    op(0, ADDR_MASTER_ENABLE, 0, 0, 64'h0, 0);
    op(0, ADDR_BIAS_HINT, 1, 0, 64'h0, 0);
    op(0, ADDR_PERF_CAPABILITY, 0, 0, 0, 1);
    op(0, ADDR_CORE_REQUEST, 0, 0, 0, 1);
    op(1, ADDR_NOTIFY_CONTROL, 0, 64'h3, 0, 0);
    op(0, ADDR_NOTIFY_CONTROL, 0, 0, 64'h3, 0);
    op(1, ADDR_BIAS_HINT, 0, 64'hFFFF_FFFF_FFFF_FFF7, 0, 0);
    op(1, ADDR_BIAS_HINT, 1, 64'hF, 0, 0);
    op(0, ADDR_BIAS_HINT, 0, 0, 64'h7, 0);
    op(0, ADDR_BIAS_HINT, 1, 0, 64'hF, 0);
    chk64({60'h0, resolvedHint}, 64'h7);
    op(1, ADDR_MASTER_ENABLE, 1, 64'h0, 0, 0);
    chk1(hwEnabled, 1'b0);
    op(1, ADDR_MASTER_ENABLE, 1, 64'h1, 0, 0);
    op(0, ADDR_MASTER_ENABLE, 0, 0, 64'h1, 0);
    chk1(legacyIgnore, 1'b1);
    op(1, ADDR_MASTER_ENABLE, 0, 64'h0, 0, 0);
    op(0, ADDR_MASTER_ENABLE, 1, 0, 64'h1, 0);
    op(1, ADDR_CORE_REQUEST, 0, 64'hFFFF_FFFF_FFFF_FFFF, 0, 0);
    op(0, ADDR_CORE_REQUEST, 0, 0, 64'h0000_07FF_FFFF_FFFF, 0);
    op(0, ADDR_CORE_REQUEST, 1, 0, 64'h0, 0);
    op(1, ADDR_PKG_REQUEST, 1, 64'hFFFF_FFFF_FFFF_FFFF, 0, 0);
    op(0, ADDR_PKG_REQUEST, 0, 0, 64'h0000_03FF_FFFF_FFFF, 0);
    op(0, ADDR_CHANGE_FLAGS, 0, 0, cap, 0);
    op(0, ADDR_PERF_CAPABILITY, 0, 0, 64'hCCCC_DDDD, 0);
    op(0, ADDR_THERMAL_STATE, 0, 0, 64'hF000, 0);
    op(0, ADDR_PRODUCTIVE_COUNT, 0, 0, prod, 0);
    op(1, ADDR_PERF_CAPABILITY, 0, 64'h1, 0, 1);
    op(0, 12'h123, 0, 0, 0, 1);
    // straps off: query words clear and the gated registers refuse
    feat = 1'b0;
    @(negedge core_clk);
    chk64({leaf6Ecx, leaf6Eax}, 64'h0);
    op(0, ADDR_BIAS_HINT, 0, 0, 0, 1);
    op(1, ADDR_NOTIFY_CONTROL, 0, 64'h0, 0, 1);
    op(0, ADDR_MASTER_ENABLE, 0, 0, 0, 1);
    feat = 1'b1;
    rst = 1'b1;
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk1(hwEnabled, 1'b0);
    wrap_up();
  end
endmodule
